// >>> hw/nfc_pkg.sv
// package of register map, field layout and types for the flash controller configuration
package nfc_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0]  NFC_OFS_CONTROL_B  = 8'h04;
  localparam logic [7:0]  NFC_OFS_GEOMETRY   = 8'h08;
  // control-b field positions
  localparam int          NFC_POS_CACHE_OFF  = 18;
  localparam int          NFC_POS_POLICY     = 16;
  localparam int          NFC_POS_SLEEP_PRM  = 8;
  localparam int          NFC_POS_EXPLICIT_W = 7;
  localparam int          NFC_POS_WAIT_CNT   = 1;
  // geometry field positions
  localparam int          NFC_POS_PAGE_SIZE  = 16;
  localparam int          NFC_POS_PAGE_COUNT = 0;
  // reset value of control-b
  localparam logic [31:0] NFC_CONTROL_B_RST  = 32'h0000_0080;
  // device variant geometry: page size code 0x0 = 8 bytes .. 0x7 = 1024 bytes
  localparam logic [2:0]  NFC_PAGE_SIZE_CODE = 3'h3;
  localparam logic [15:0] NFC_PAGE_COUNT     = 16'h0100;
  // miss policy codes
  typedef enum logic [1:0] {
    NFC_POLICY_FAST   = 2'h0,  // no added wait on miss
    NFC_POLICY_LOWPWR = 2'h1,  // one extra wait on every miss
    NFC_POLICY_DETERM = 2'h2,  // hit and miss take the same time
    NFC_POLICY_RSVD   = 2'h3   // reserved, handled like fast
  } nfc_policy_t;
  // sleep power reduction codes
  typedef enum logic [1:0] {
    NFC_SLP_WAKE_FETCH = 2'h0,  // wake_on_first_fetch
    NFC_SLP_WAKE_SYS   = 2'h1,  // wake_with_system
    NFC_SLP_RSVD       = 2'h2,  // reserved, handled like off
    NFC_SLP_OFF        = 2'h3   // no automatic power reduction
  } nfc_sleep_t;
  // control-b fields as stored
  typedef struct packed {
    logic        cache_off;
    nfc_policy_t miss_policy;
    nfc_sleep_t  sleep_power_reduction;
    logic        explicit_write;
    logic [3:0]  read_wait_count;
  } nfc_ctrl_t;
  // peripheral bus request
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } nfc_apb_req_t;
  // fetch request from the core side
  typedef struct packed {
    logic valid;  // held until ready
    logic hit;    // cache tag lookup result
  } nfc_fetch_t;
  // page buffer write event
  typedef struct packed {
    logic        write;      // one-cycle pulse per word written
    logic        last_word;  // this write hits the final word of the buffer
    logic        aux_row;    // target is an auxiliary row
    logic [21:0] page_addr;  // address of this write
  } nfc_pbuf_t;
endpackage : nfc_pkg

// >>> hw/nfc_config.sv
// configuration logic of the flash controller: control-b, geometry, waits, sleep, auto write
//
// Contract
// - cache_off set disables cache, clear enables
// - policy 0x0: no wait added on miss
// - policy 0x1: one extra wait per miss
// - policy 0x2: hit equals miss, wait count
// - sleep code 0x0: wake at first access
// - sleep code 0x1: wake when sleep ends
// - sleep code 0x3: no power reduction; 0x2 reserved
// - explicit_write 0: last word starts page write
// - explicit_write 1: only commands start writes
// - control-b resets to 0x00000080
// - wait states equal field bits 4:1
// - wait field resets to zero
// - geometry read-only: size code, page count
// - size code powers of two, 8..1024
// - page count gives main array pages
module nfc_config
  import nfc_pkg::*;
(
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   reset,
  // peripheral register bus
  input  wire nfc_pkg::nfc_apb_req_t  apb_req,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // core fetch path
  input  wire nfc_pkg::nfc_fetch_t    fetch,
  output logic                        fetch_ready,
  output logic                        cache_enable,
  // power management
  input  wire logic                   sys_sleep,
  output logic                        flash_lowpower,
  // page buffer and write engine
  input  wire nfc_pkg::nfc_pbuf_t     pbuf,
  output logic                        page_write_start,
  output logic [21:0]                 page_write_addr,
  output logic                        page_write_aux
);
  import nfc_pkg::*;

  typedef enum {NFC_ST_IDLE, NFC_ST_WAIT} nfc_state_t;

  nfc_ctrl_t   ctrl_reg,  ctrl_next;    // control-b fields
  logic [31:0] rdata_reg, rdata_next;   // read data latched in setup
  logic        err_reg,   err_next;     // unmapped access answer
  nfc_state_t  state_reg, state_next;   // fetch wait state
  logic [4:0]  cnt_reg,   cnt_next;     // remaining wait cycles
  logic        lp_reg,    lp_next;      // flash in low-power state
  logic        slp_q_reg, slp_q_next;   // sleep delayed, for edge
  logic        wst_reg,   wst_next;     // page write start pulse
  logic [21:0] wadr_reg,  wadr_next;    // page addressed by last write
  logic        waux_reg,  waux_next;    // last write aimed at aux row
  logic [4:0]  waits;                   // waits for the current fetch
  logic        setup, access, hit_ctl, hit_geo;

  // bus decode
  always_comb begin
    setup   = apb_req.psel && !apb_req.penable;
    access  = apb_req.psel && apb_req.penable;
    hit_ctl = (apb_req.paddr == NFC_OFS_CONTROL_B);
    hit_geo = (apb_req.paddr == NFC_OFS_GEOMETRY);
  end

  // register file next state
  always_comb begin
    ctrl_next  = ctrl_reg;
    rdata_next = rdata_reg;
    err_next   = err_reg;
    if (setup) begin
      // read data and error answer prepared for the access phase
      err_next   = !(hit_ctl || hit_geo);
      rdata_next = 32'h0;
      if (hit_ctl) begin
        rdata_next[NFC_POS_CACHE_OFF]                   = ctrl_reg.cache_off;
        rdata_next[NFC_POS_POLICY +: 2]                 = ctrl_reg.miss_policy;
        rdata_next[NFC_POS_SLEEP_PRM +: 2]              = ctrl_reg.sleep_power_reduction;
        rdata_next[NFC_POS_EXPLICIT_W]                  = ctrl_reg.explicit_write;
        rdata_next[NFC_POS_WAIT_CNT +: 4]               = ctrl_reg.read_wait_count;
      end else if (hit_geo) begin
        // geometry is fixed; writes to it are ignored
        rdata_next[NFC_POS_PAGE_SIZE +: 3]  = NFC_PAGE_SIZE_CODE;
        rdata_next[NFC_POS_PAGE_COUNT +: 16] = NFC_PAGE_COUNT;
      end
    end
    if (access && apb_req.pwrite && hit_ctl) begin
      // all fields store as written, reserved codes included
      ctrl_next.cache_off             = apb_req.pwdata[NFC_POS_CACHE_OFF];
      ctrl_next.miss_policy           = nfc_policy_t'(apb_req.pwdata[NFC_POS_POLICY +: 2]);
      ctrl_next.sleep_power_reduction = nfc_sleep_t'(apb_req.pwdata[NFC_POS_SLEEP_PRM +: 2]);
      ctrl_next.explicit_write        = apb_req.pwdata[NFC_POS_EXPLICIT_W];
      ctrl_next.read_wait_count       = apb_req.pwdata[NFC_POS_WAIT_CNT +: 4];
    end
  end

  // register file flops
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ctrl_reg  <= nfc_ctrl_t'({NFC_CONTROL_B_RST[NFC_POS_CACHE_OFF],
                                NFC_CONTROL_B_RST[NFC_POS_POLICY +: 2],
                                NFC_CONTROL_B_RST[NFC_POS_SLEEP_PRM +: 2],
                                NFC_CONTROL_B_RST[NFC_POS_EXPLICIT_W],
                                NFC_CONTROL_B_RST[NFC_POS_WAIT_CNT +: 4]});
      rdata_reg <= 32'h0;
      err_reg   <= 1'b0;
    end else begin
      ctrl_reg  <= ctrl_next;
      rdata_reg <= rdata_next;
      err_reg   <= err_next;
    end
  end

  // bus answer: no wait states, error only in access phase
  always_comb begin
    pready  = 1'b1;
    pslverr = access && err_reg;
    prdata  = rdata_reg;
  end

  // wait cycles for a fetch from policy, hit and wait count
  always_comb begin
    waits = {1'b0, ctrl_reg.read_wait_count};
    if (ctrl_reg.cache_off) begin
      waits = {1'b0, ctrl_reg.read_wait_count};
    end else begin
      unique case (ctrl_reg.miss_policy)
        NFC_POLICY_FAST, NFC_POLICY_RSVD: begin
          waits = fetch.hit ? 5'h00 : {1'b0, ctrl_reg.read_wait_count};
        end
        NFC_POLICY_LOWPWR: begin
          waits = fetch.hit ? 5'h00 : 5'({1'b0, ctrl_reg.read_wait_count} + 5'h01);
        end
        NFC_POLICY_DETERM: begin
          waits = {1'b0, ctrl_reg.read_wait_count};
        end
      endcase
    end
  end

  // fetch wait sequencer; a fetch waits in idle while the flash is in low power
  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    fetch_ready = 1'b0;
    unique case (state_reg)
      NFC_ST_IDLE: begin
        if (fetch.valid && !lp_reg) begin
          if (waits == 5'h00) begin
            fetch_ready = 1'b1;
          end else begin
            state_next = NFC_ST_WAIT;
            cnt_next   = 5'(waits - 5'h01);
          end
        end
      end
      NFC_ST_WAIT: begin
        if (cnt_reg == 5'h00) begin
          fetch_ready = 1'b1;
          state_next  = NFC_ST_IDLE;
        end else begin
          cnt_next = 5'(cnt_reg - 5'h01);
        end
      end
    endcase
  end

  // sleep power reduction next state
  always_comb begin
    slp_q_next = sys_sleep;
    lp_next    = lp_reg;
    unique case (ctrl_reg.sleep_power_reduction)
      NFC_SLP_WAKE_FETCH: begin
        if (sys_sleep && !slp_q_reg) lp_next = 1'b1;
        else if (fetch.valid)        lp_next = 1'b0;
      end
      NFC_SLP_WAKE_SYS: begin
        lp_next = sys_sleep;
      end
      NFC_SLP_RSVD, NFC_SLP_OFF: begin
        lp_next = 1'b0;
      end
    endcase
  end

  // automatic page write next state
  always_comb begin
    wst_next  = pbuf.write && pbuf.last_word && !ctrl_reg.explicit_write;
    wadr_next = pbuf.write ? pbuf.page_addr : wadr_reg;
    waux_next = pbuf.write ? pbuf.aux_row : waux_reg;
  end

  // sequencer, sleep and write flops
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg <= NFC_ST_IDLE;
      cnt_reg   <= 5'h00;
      lp_reg    <= 1'b0;
      slp_q_reg <= 1'b0;
      wst_reg   <= 1'b0;
      wadr_reg  <= 22'h0;
      waux_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      lp_reg    <= lp_next;
      slp_q_reg <= slp_q_next;
      wst_reg   <= wst_next;
      wadr_reg  <= wadr_next;
      waux_reg  <= waux_next;
    end
  end

  // outputs
  always_comb begin
    cache_enable     = !ctrl_reg.cache_off;
    flash_lowpower   = lp_reg;
    page_write_start = wst_reg;
    page_write_addr  = wadr_reg;
    page_write_aux   = waux_reg;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // cache enable must follow the cache_off bit of the last control-b write
  a_cache_off_follows: assert property (apb_req.psel && apb_req.penable && apb_req.pwrite
      && apb_req.paddr == NFC_OFS_CONTROL_B
      |=> cache_enable == !$past(apb_req.pwdata[NFC_POS_CACHE_OFF]))
    else $error("cache enable disagrees with cache_off");
  a_fast_hit_now: assert property (state_reg == NFC_ST_IDLE && fetch.valid && fetch.hit && !lp_reg
      && !ctrl_reg.cache_off && ctrl_reg.miss_policy == NFC_POLICY_FAST |-> fetch_ready)
    else $error("fast policy hit was stalled");
  a_lowpwr_miss_extra: assert property (state_reg == NFC_ST_IDLE && fetch.valid && !fetch.hit
      && !lp_reg && !ctrl_reg.cache_off && ctrl_reg.miss_policy == NFC_POLICY_LOWPWR
      && ctrl_reg.read_wait_count == 4'h0 |-> !fetch_ready ##1 fetch_ready)
    else $error("low power miss lacks one wait");
  a_determ_hit_waits: assert property (state_reg == NFC_ST_IDLE && fetch.valid && fetch.hit
      && !lp_reg && !ctrl_reg.cache_off && ctrl_reg.miss_policy == NFC_POLICY_DETERM
      && ctrl_reg.read_wait_count == 4'h3 |-> !fetch_ready [*3] ##1 fetch_ready)
    else $error("deterministic hit not at wait count");
  a_wake_on_fetch: assert property (lp_reg && fetch.valid && !(sys_sleep && !slp_q_reg)
      && ctrl_reg.sleep_power_reduction == NFC_SLP_WAKE_FETCH |=> !flash_lowpower)
    else $error("first access did not wake flash");
  a_wake_with_sys: assert property (ctrl_reg.sleep_power_reduction == NFC_SLP_WAKE_SYS
      && $stable(ctrl_reg) |=> flash_lowpower == $past(sys_sleep))
    else $error("low power does not follow sleep");
  a_no_auto_lp: assert property (ctrl_reg.sleep_power_reduction == NFC_SLP_OFF
      && $stable(ctrl_reg) |=> !flash_lowpower)
    else $error("power reduced while disabled");
  a_auto_write_fire: assert property (pbuf.write && pbuf.last_word && !ctrl_reg.explicit_write
      |=> page_write_start && page_write_addr == $past(pbuf.page_addr))
    else $error("auto page write missing or wrong page");
  a_manual_no_write: assert property (ctrl_reg.explicit_write |=> !page_write_start)
    else $error("page write started in explicit mode");
  a_geometry_fixed: assert property (apb_req.psel && !apb_req.penable
      && apb_req.paddr == NFC_OFS_GEOMETRY |=> prdata == {13'h0, NFC_PAGE_SIZE_CODE,
      NFC_PAGE_COUNT})
    else $error("geometry read wrong");
endmodule : nfc_config

// >>> test/nfc_core_model.sv
// behavioural processor core that issues flash fetches and times the answer
module nfc_core_model
  import nfc_pkg::*;
(
  // clock
  input  wire logic                 mclk,
  // fetch path toward the controller
  output nfc_pkg::nfc_fetch_t       fetch,
  input  wire logic                 fetch_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  import nfc_pkg::*;

  // idle fetch port at time zero
  initial begin
    fetch = '{valid: 1'b0, hit: 1'b0};
  end

  // one fetch: raise valid after an edge, hold it with hit until ready, count waited cycles
  task automatic do_fetch(input logic hit, output int lat);
    begin
      @(posedge mclk);
      fetch <= '{valid: 1'b1, hit: hit};
      lat = 0;
      #1;
      // bounded wait, a hang shows up as a latency of 40
      while (fetch_ready !== 1'b1 && lat < 40) begin
        @(posedge mclk);
        #1;
        lat++;
      end
      @(posedge mclk);
      // released hit no longer shows the old value
      fetch <= '{valid: 1'b0, hit: ~hit};
    end
  endtask : do_fetch
endmodule : nfc_core_model

// >>> test/tb_top.sv
// self-checking bench for the flash controller configuration block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import nfc_pkg::*;

  logic                mclk;              // system clock
  logic                reset;             // async reset, active high
  nfc_apb_req_t        apb_req;           // register bus request
  logic [31:0]         prdata;            // register read data
  logic                pready;            // bus ready
  logic                pslverr;           // bus error
  nfc_fetch_t          fetch;             // core fetch request
  logic                fetch_ready;       // fetch completion
  logic                cache_enable;      // cache on
  logic                sys_sleep;         // system sleep level
  logic                flash_lowpower;    // flash in low power
  nfc_pbuf_t           pbuf;              // page buffer write event
  logic                page_write_start;  // page programming start
  logic [21:0]         page_write_addr;   // page programming address
  logic                page_write_aux;    // page programming aux row
  int                  err_count;         // mismatches
  int                  total_checks;      // comparisons made
  logic [31:0]         rd;                // last read data
  logic                er;                // last bus error
  int                  lat;               // last fetch latency
  int                  wcs [3];           // wait counts tried
  int                  e;                 // expected latency

  // 100 MHz clock
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  nfc_config u_nfc_config (.mclk(mclk), .reset(reset), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fetch(fetch), .fetch_ready(fetch_ready),
    .cache_enable(cache_enable), .sys_sleep(sys_sleep), .flash_lowpower(flash_lowpower),
    .pbuf(pbuf), .page_write_start(page_write_start), .page_write_addr(page_write_addr),
    .page_write_aux(page_write_aux));

  nfc_core_model u_nfc_core_model (.mclk(mclk), .fetch(fetch), .fetch_ready(fetch_ready));

  // verdict and end of run
  task automatic test_done;
    begin
      if (err_count == 0 && total_checks > 0) begin
        $display("STATUS OK");
      end else begin
        $display("STATUS NOT OK");
      end
      $finish;
    end
  endtask : test_done

  // compare one value and count it
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    begin
      total_checks++;
      if (got !== exp) begin
        $display("Error %s expected %h seen %h", name, exp, got);
        err_count++;
      end
    end
  endtask : chk

  // one register bus transfer: setup, access, sample in access phase, release
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int k;
    begin
      k = 0;
      @(posedge mclk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge mclk);
      apb_req.penable <= 1'b1;
      #1;
      while (pready !== 1'b1) begin
        if (k == 8) begin
          $display("Error pready expected 1 seen 0");
          err_count++;
          test_done();
        end
        @(posedge mclk);
        #1;
        k++;
      end
      q = prdata;
      err = pslverr;
      @(posedge mclk);
      apb_req <= '{psel: 1'b0, penable: 1'b0, pwrite: ~w, paddr: ~a, pwdata: ~d};
    end
  endtask : apb

  // register write, expecting no error
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    begin
      apb(1'b1, a, d, rd, er);
      chk("write error", 32'h0, {31'h0, er});
    end
  endtask : wr

  // register read and compare
  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    begin
      apb(1'b0, a, 32'h0, rd, er);
      chk(name, exp, rd);
    end
  endtask : rdc

  // control-b word from its fields
  function automatic logic [31:0] mk(input logic co, input logic [1:0] pol, input logic [1:0] slp,
                                     input logic ew, input logic [3:0] wc);
    return {13'h0, co, pol, 6'h0, slp, ew, 2'h0, wc, 1'b0};
  endfunction : mk

  // one fetch and its latency check
  task automatic fet(input logic hit, input int exp);
    begin
      u_nfc_core_model.do_fetch(hit, lat);
      chk("fetch latency", 32'(exp), 32'(lat));
      if (lat >= 40) test_done();
    end
  endtask : fet

  // one page buffer word write, then check the programming start
  task automatic pbw(input logic last, input logic aux, input logic [21:0] a, input logic exp);
    begin
      @(posedge mclk);
      pbuf <= '{write: 1'b1, last_word: last, aux_row: aux, page_addr: a};
      @(posedge mclk);
      pbuf <= '{write: 1'b0, last_word: ~last, aux_row: ~aux, page_addr: ~a};
      #1;
      chk("page_write_start", {31'h0, exp}, {31'h0, page_write_start});
      chk("page_write_addr", {10'h0, a}, {10'h0, page_write_addr});
      chk("page_write_aux", {31'h0, aux}, {31'h0, page_write_aux});
    end
  endtask : pbw

  // main sequence
  initial begin
    reset = 1'b1;
    apb_req = '0;
    sys_sleep = 1'b0;
    pbuf = '0;
    err_count = 0;
    total_checks = 0;
    wcs = '{0, 3, 15};
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    #1;
    chk("cache_enable", 32'h1, {31'h0, cache_enable});
    rdc("control_b reset", NFC_OFS_CONTROL_B, 32'h0000_0080);
    rdc("geometry", NFC_OFS_GEOMETRY, {13'h0, NFC_PAGE_SIZE_CODE, NFC_PAGE_COUNT});
    wr(NFC_OFS_GEOMETRY, 32'hffff_ffff);
    rdc("geometry kept", NFC_OFS_GEOMETRY, {13'h0, NFC_PAGE_SIZE_CODE, NFC_PAGE_COUNT});
    apb(1'b0, 8'h0c, 32'h0, rd, er);
    chk("unmapped error", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    wr(NFC_OFS_CONTROL_B, 32'hffff_ffff);
    rdc("control_b fields", NFC_OFS_CONTROL_B, mk(1'b1, 2'h3, 2'h3, 1'b1, 4'hf));
    chk("cache_enable off", 32'h0, {31'h0, cache_enable});
    fet(1'b1, 15);
    // every miss policy, hit and miss, at wait counts 0, 3 and 15
    foreach (wcs[i]) begin
      for (int pol = 0; pol < 4; pol++) begin
        wr(NFC_OFS_CONTROL_B, mk(1'b0, 2'(pol), 2'h3, 1'b1, 4'(wcs[i])));
        for (int h = 0; h < 2; h++) begin
          e = (pol == 2) ? wcs[i] : (h == 1) ? 0 : (pol == 1) ? wcs[i] + 1 : wcs[i];
          fet(1'(h), e);
        end
      end
    end
    // every sleep power reduction code
    for (int s = 0; s < 4; s++) begin
      wr(NFC_OFS_CONTROL_B, mk(1'b0, 2'h0, 2'(s), 1'b1, 4'h0));
      @(posedge mclk);
      sys_sleep <= 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      chk("lowpower in sleep", {31'h0, s < 2}, {31'h0, flash_lowpower});
      @(posedge mclk);
      sys_sleep <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      chk("lowpower after sleep", {31'h0, s == 0}, {31'h0, flash_lowpower});
      if (s == 0) begin
        fet(1'b1, 1);
        chk("lowpower after fetch", 32'h0, {31'h0, flash_lowpower});
      end
    end
    // automatic page write, then explicit write mode
    wr(NFC_OFS_CONTROL_B, mk(1'b0, 2'h0, 2'h3, 1'b0, 4'h0));
    pbw(1'b0, 1'b0, 22'h0a5a5a, 1'b0);
    pbw(1'b1, 1'b1, 22'h155aa5, 1'b1);
    pbw(1'b1, 1'b0, 22'h3c0f0f, 1'b1);
    wr(NFC_OFS_CONTROL_B, mk(1'b0, 2'h0, 2'h3, 1'b1, 4'h0));
    pbw(1'b1, 1'b0, 22'h2b3c4d, 1'b0);
    test_done();
  end
endmodule : tb_top
